// >>> tdm_adapt_pkg.sv
// Purpose: Shared constants, types and helpers for the TDM emulation adapter
// Assumes: One 100 MHz clock; 32-bit words on both the emulation and ring sides
// Notes: Ring data unit = header beat, payload beats, CRC trailer beat
//
// Overview of operation
// - Transmit blocks fixed length, fixed spacing
// - Receive blocks delivered fixed length, spacing
// - Sequence checks count lost, duplicated separately
// - Plesiochronous circuits default 512-octet payload
// - All video services default 188-octet payload
// - Voiceband and ISDN default 512-octet payload
// - Structured block fixed, multiple of 32 bits
// - Marker is boundary on first block part
// - Error flag marks dummy fill, else clear
// - Marker use fixed at connection setup
// - Period in seconds, 15 min/24 h defaults
// - Independent lost and duplicate counters per tributary
// - Counters cleared to zero at start-up
// - Counts held in two dedicated registers
// - Quiet period expiry restarts timer, no report
// - Eventful expiry reports counts, restarts timer
// - CRC per unit, periodic CRC count reported; code strobes the report only when a lost or duplicate count is nonzero
package tdm_adapt_pkg;
	localparam int NTRIB = 4; // Tributaries watched on receive
	localparam int TRIB_W = 2;
	localparam int SEQ_W = 8; // Frame sequence number width
	localparam int CNT_W = 16; // Lost and duplicate counter width
	localparam int WORD_W = 32;
	localparam int WORD_OCTETS = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int LEN_PDH = 512; // Octets
	localparam int LEN_VIDEO = 188; // Octets
	localparam int LEN_VOICE = 512; // Octets
	localparam int CLK_PERIOD_NS = 10;
	localparam int SECOND_NS = 1_000_000_000;
	localparam int CYCLES_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
	localparam logic [31:0] PERIOD_15M_S = 32'h0000_0384; // 900 s
	localparam logic [31:0] PERIOD_24H_S = 32'h0001_5180; // 86400 s
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam int HDR_SEQ_LSB = 0; // Header word field positions
	localparam int HDR_TRIB_LSB = 8;
	localparam int HDR_BOUND_BIT = 10;
	localparam int HDR_DUMMY_BIT = 11;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

	// Service kinds that fix the payload length
	typedef enum logic [2:0] {
		SVC_PDH_SYNC, SVC_PDH_ASYNC, SVC_VID_TV, SVC_VID_HIGH,
		SVC_VID_P64, SVC_VOICE, SVC_ISDN_64, SVC_ISDN_HIGH
	} service_t;

	// One word of a user block from the emulation layer
	typedef struct packed {
		logic bound; // First word of a structured block
		logic [WORD_W-1:0] data;
	} tx_word_t;

	// One beat of the ring aggregate pipe
	typedef struct packed {
		logic sof;
		logic eof;
		logic [WORD_W-1:0] data;
	} mac_beat_t;

	// One delivered word towards the emulation layer
	typedef struct packed {
		logic bound;
		logic error;
		logic last;
		logic [WORD_W-1:0] data;
	} rx_word_t;

	typedef logic [NTRIB-1:0][CNT_W-1:0] cnt_array_t;

	// Payload words per data unit for a service
	function automatic logic [7:0] pdu_words(input service_t svc);
		case (svc)
			SVC_VID_TV, SVC_VID_HIGH, SVC_VID_P64: return 8'(LEN_VIDEO / WORD_OCTETS);
			SVC_VOICE, SVC_ISDN_64, SVC_ISDN_HIGH: return 8'(LEN_VOICE / WORD_OCTETS);
			default: return 8'(LEN_PDH / WORD_OCTETS);
		endcase
	endfunction

	// CRC-16 step over one 32-bit word, MSB first
	function automatic logic [15:0] crc16_word(input logic [15:0] c, input logic [31:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
		end
		return r;
	endfunction
endpackage

// >>> tdm_emulation_adapter.sv
// Purpose: Adapter between TDM emulation layer and ring aggregate pipe
// Assumes: Same-clock partners; ring pipe keeps beat order within a unit
// Notes: Loss/duplicate counting per tributary with periodic reporting
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Word FIFO with registered flags
module tdm_word_fifo #(
	parameter int W = 33,
	parameter int DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_in_valid,
	input wire logic [W-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [W-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH]; // Storage flops
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// Pointer and occupancy next values
	always_comb begin
		push = i_in_valid && o_in_ready;
		pop = o_out_valid && i_out_ready;
		next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Register pointers, flags and written word
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			o_in_ready <= 1'b0;
			o_out_valid <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			o_in_ready <= (next_count < (AW+1)'(DEPTH)); // Honest full
			o_out_valid <= (next_count != '0); // Honest empty
			if (push) begin
				mem[wr_ptr] <= i_in_data;
			end
		end
	end

	assign o_out_data = mem[rd_ptr];
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top: transmit framer, receive deframer, sequence monitor
module tdm_emulation_adapter import tdm_adapt_pkg::*; #(
	parameter int T_SEC_CYCLES = CYCLES_PER_SEC // Cycles per second
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_conn_up, // Connection established
	input wire service_t i_service, // Service kind, taken at setup
	input wire logic i_struct_en, // Structure marker use, taken at setup
	input wire logic [TRIB_W-1:0] i_tx_trib, // Own transmit tributary
	input wire logic [31:0] i_period_sec, // Monitoring period, 0 = default
	input wire logic i_period_long, // Default picks 24 h instead of 15 min
	input wire logic i_tx_valid,
	input wire tx_word_t i_tx_word,
	output logic o_tx_ready,
	output logic o_mac_tx_valid,
	output var mac_beat_t o_mac_tx_beat,
	input wire logic i_mac_tx_ready,
	input wire logic i_mac_rx_valid,
	input wire mac_beat_t i_mac_rx_beat,
	output logic o_rx_valid,
	output var rx_word_t o_rx_word,
	output var cnt_array_t o_lost_count, // Live lost counts
	output var cnt_array_t o_dup_count, // Live duplicate counts
	output logic o_report_valid, // One-cycle report strobe
	output var cnt_array_t o_report_lost,
	output var cnt_array_t o_report_dup,
	output logic [CNT_W-1:0] o_report_crc
);
	////////////////////////////////////////////////////////////////////////
	// Connection settings, frozen while the connection runs
	logic conn_q, next_conn_q;
	service_t svc, next_svc;
	logic struct_on, next_struct_on;
	logic [7:0] words; // Payload words per unit

	// Capture settings on the rising edge of connection up
	always_comb begin
		next_conn_q = i_conn_up;
		next_svc = svc;
		next_struct_on = struct_on;
		if (i_conn_up && !conn_q) begin
			next_svc = i_service;
			next_struct_on = i_struct_en;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			conn_q <= 1'b0;
			svc <= SVC_PDH_SYNC;
			struct_on <= 1'b0;
		end else begin
			conn_q <= next_conn_q;
			svc <= next_svc;
			struct_on <= next_struct_on;
		end
	end

	assign words = pdu_words(svc);

	////////////////////////////////////////////////////////////////////////
	// Transmit FIFO
	tx_word_t fifo_head;
	logic fifo_valid, fifo_pop;

	tdm_word_fifo #(.W($bits(tx_word_t)), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_in_valid(i_tx_valid),
		.i_in_data(i_tx_word),
		.o_in_ready(o_tx_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_head),
		.i_out_ready(fifo_pop)
	);

	////////////////////////////////////////////////////////////////////////
	// Transmit framer
	typedef enum logic [1:0] {TX_IDLE, TX_PAY, TX_CRC} tx_state_t;
	tx_state_t tx_st, next_tx_st;
	logic [7:0] tx_cnt, next_tx_cnt;
	logic [SEQ_W-1:0] tx_seq, next_tx_seq;
	logic [15:0] tx_crc, next_tx_crc;
	logic next_mac_valid;
	mac_beat_t next_mac_beat;
	logic slot_free; // Output beat register may take a new beat

	// Next transmit state and output beat
	always_comb begin
		slot_free = !o_mac_tx_valid || i_mac_tx_ready;
		next_tx_st = tx_st;
		next_tx_cnt = tx_cnt;
		next_tx_seq = tx_seq;
		next_tx_crc = tx_crc;
		next_mac_valid = o_mac_tx_valid && !i_mac_tx_ready;
		next_mac_beat = o_mac_tx_beat;
		fifo_pop = 1'b0;
		case (tx_st)
			TX_IDLE: begin
				if (conn_q && fifo_valid && slot_free) begin
					next_mac_valid = 1'b1;
					next_mac_beat = '{sof: 1'b1, eof: 1'b0, data: '0};
					next_mac_beat.data[HDR_SEQ_LSB +: SEQ_W] = tx_seq;
					next_mac_beat.data[HDR_TRIB_LSB +: TRIB_W] = i_tx_trib;
					next_mac_beat.data[HDR_BOUND_BIT] = struct_on && fifo_head.bound;
					next_tx_cnt = '0;
					next_tx_crc = CRC_INIT;
					next_tx_st = TX_PAY;
				end
			end
			TX_PAY: begin
				if (fifo_valid && slot_free) begin
					fifo_pop = 1'b1;
					next_mac_valid = 1'b1;
					next_mac_beat = '{sof: 1'b0, eof: 1'b0, data: fifo_head.data};
					next_tx_crc = crc16_word(tx_crc, fifo_head.data);
					next_tx_cnt = tx_cnt + 8'h01;
					if (tx_cnt == words - 8'h01) begin
						next_tx_st = TX_CRC; // Fixed block length
					end
				end
			end
			TX_CRC: begin
				if (slot_free) begin
					next_mac_valid = 1'b1;
					next_mac_beat = '{sof: 1'b0, eof: 1'b1, data: {16'h0000, tx_crc}};
					next_tx_seq = tx_seq + SEQ_W'(1);
					next_tx_st = TX_IDLE;
				end
			end
			default: begin
				next_tx_st = TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_st <= TX_IDLE;
			tx_cnt <= '0;
			tx_seq <= '0;
			tx_crc <= CRC_INIT;
			o_mac_tx_valid <= 1'b0;
			o_mac_tx_beat <= '0;
		end else begin
			tx_st <= next_tx_st;
			tx_cnt <= next_tx_cnt;
			tx_seq <= next_tx_seq;
			tx_crc <= next_tx_crc;
			o_mac_tx_valid <= next_mac_valid;
			o_mac_tx_beat <= next_mac_beat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive deframer
	typedef enum logic [1:0] {RX_HDR, RX_PAY, RX_TRL} rx_state_t;
	rx_state_t rx_st, next_rx_st;
	logic [7:0] rx_cnt, next_rx_cnt;
	logic [15:0] rx_crc, next_rx_crc;
	logic rx_bound, next_rx_bound, rx_dummy, next_rx_dummy;
	logic next_rx_valid;
	rx_word_t next_rx_word;
	logic seq_evt; // Header accepted this cycle
	logic [TRIB_W-1:0] seq_trib;
	logic [SEQ_W-1:0] seq_num;
	logic crc_evt; // Trailer mismatch this cycle

	// Next receive state and delivered word
	always_comb begin
		next_rx_st = rx_st;
		next_rx_cnt = rx_cnt;
		next_rx_crc = rx_crc;
		next_rx_bound = rx_bound;
		next_rx_dummy = rx_dummy;
		next_rx_valid = 1'b0;
		next_rx_word = o_rx_word;
		seq_evt = 1'b0;
		seq_trib = i_mac_rx_beat.data[HDR_TRIB_LSB +: TRIB_W];
		seq_num = i_mac_rx_beat.data[HDR_SEQ_LSB +: SEQ_W];
		crc_evt = 1'b0;
		case (rx_st)
			RX_HDR: begin
				if (i_mac_rx_valid && i_mac_rx_beat.sof) begin
					seq_evt = 1'b1;
					next_rx_bound = struct_on && i_mac_rx_beat.data[HDR_BOUND_BIT];
					next_rx_dummy = i_mac_rx_beat.data[HDR_DUMMY_BIT];
					next_rx_cnt = '0;
					next_rx_crc = CRC_INIT;
					next_rx_st = RX_PAY;
				end
			end
			RX_PAY: begin
				if (i_mac_rx_valid) begin
					next_rx_valid = 1'b1;
					next_rx_word.data = i_mac_rx_beat.data;
					next_rx_word.bound = rx_bound && (rx_cnt == 8'h00);
					next_rx_word.error = rx_dummy;
					next_rx_word.last = (rx_cnt == words - 8'h01);
					next_rx_crc = crc16_word(rx_crc, i_mac_rx_beat.data);
					next_rx_cnt = rx_cnt + 8'h01;
					if (rx_cnt == words - 8'h01) begin
						next_rx_st = RX_TRL;
					end
				end
			end
			RX_TRL: begin
				if (i_mac_rx_valid) begin
					crc_evt = (i_mac_rx_beat.data[15:0] != rx_crc);
					next_rx_st = RX_HDR;
				end
			end
			default: begin
				next_rx_st = RX_HDR;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_st <= RX_HDR;
			rx_cnt <= '0;
			rx_crc <= CRC_INIT;
			rx_bound <= 1'b0;
			rx_dummy <= 1'b0;
			o_rx_valid <= 1'b0;
			o_rx_word <= '0;
		end else begin
			rx_st <= next_rx_st;
			rx_cnt <= next_rx_cnt;
			rx_crc <= next_rx_crc;
			rx_bound <= next_rx_bound;
			rx_dummy <= next_rx_dummy;
			o_rx_valid <= next_rx_valid;
			o_rx_word <= next_rx_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Monitoring timer
	logic [31:0] pre_cnt, next_pre_cnt, sec_cnt, next_sec_cnt, period;
	logic expire;

	// Seconds prescaler and period counter
	always_comb begin
		period = (i_period_sec != 32'h0) ? i_period_sec :
			(i_period_long ? PERIOD_24H_S : PERIOD_15M_S);
		next_pre_cnt = pre_cnt + 32'h1;
		next_sec_cnt = sec_cnt;
		expire = 1'b0;
		if (pre_cnt >= 32'(T_SEC_CYCLES - 1)) begin
			next_pre_cnt = '0;
			next_sec_cnt = sec_cnt + 32'h1;
			if (sec_cnt + 32'h1 >= period) begin
				expire = 1'b1;
				next_sec_cnt = '0; // Restart
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pre_cnt <= '0;
			sec_cnt <= '0;
		end else begin
			pre_cnt <= next_pre_cnt;
			sec_cnt <= next_sec_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-tributary sequence check and counters
	cnt_array_t next_lost, next_dup;
	logic [NTRIB-1:0] any_hit; // Tributary saw loss or duplicate
	logic [CNT_W-1:0] crc_cnt, next_crc_cnt;

	genvar t;
	generate
		for (t = 0; t < NTRIB; t++) begin : g_trib
			logic [SEQ_W-1:0] exp_seq, next_exp_seq;
			logic seen, next_seen;
			logic [SEQ_W-1:0] gap;
			logic [CNT_W:0] lsum;
			logic [CNT_W-1:0] lbase, dbase;

			// Classify the header and update this tributary only
			always_comb begin
				gap = seq_num - exp_seq;
				next_exp_seq = exp_seq;
				next_seen = seen;
				lbase = expire ? CNT_RST : o_lost_count[t];
				dbase = expire ? CNT_RST : o_dup_count[t];
				lsum = {1'b0, lbase};
				next_dup[t] = dbase;
				if (seq_evt && seq_trib == TRIB_W'(t)) begin
					next_seen = 1'b1;
					if (!seen || gap == '0) begin
						next_exp_seq = seq_num + SEQ_W'(1);
					end else if (!gap[SEQ_W-1]) begin
						lsum = {1'b0, lbase} + (CNT_W+1)'(gap);
						next_exp_seq = seq_num + SEQ_W'(1);
					end else if (dbase != CNT_MAX) begin
						next_dup[t] = dbase + CNT_W'(1);
					end
				end
				next_lost[t] = lsum[CNT_W] ? CNT_MAX : lsum[CNT_W-1:0];
			end

			always_ff @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					exp_seq <= '0;
					seen <= 1'b0;
					o_lost_count[t] <= CNT_RST;
					o_dup_count[t] <= CNT_RST;
				end else begin
					exp_seq <= next_exp_seq;
					seen <= next_seen;
					o_lost_count[t] <= next_lost[t];
					o_dup_count[t] <= next_dup[t];
				end
			end

			assign any_hit[t] = (o_lost_count[t] != CNT_RST) || (o_dup_count[t] != CNT_RST);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// CRC mismatch count and management report
	always_comb begin
		next_crc_cnt = expire ? CNT_RST : crc_cnt;
		if (crc_evt && next_crc_cnt != CNT_MAX) begin
			next_crc_cnt = next_crc_cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			crc_cnt <= CNT_RST;
			o_report_valid <= 1'b0;
			o_report_lost <= '0;
			o_report_dup <= '0;
			o_report_crc <= CNT_RST;
		end else begin
			crc_cnt <= next_crc_cnt;
			o_report_valid <= expire && (|any_hit);
			if (expire) begin
				o_report_lost <= o_lost_count;
				o_report_dup <= o_dup_count;
				o_report_crc <= crc_cnt;
			end
		end
	end
endmodule

`default_nettype wire

// >>> tdm_adapt_assertions.sv
// Purpose: Port checker for the TDM emulation adapter
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to the top module after the checker
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tdm_adapt_checker import tdm_adapt_pkg::*; #(
	parameter int T_SEC_CYCLES = CYCLES_PER_SEC // Kept in step with the top
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_conn_up,
	input wire service_t i_service,
	input wire logic i_mac_tx_ready,
	input wire logic i_mac_rx_valid,
	input wire mac_beat_t i_mac_rx_beat,
	input wire logic o_mac_tx_valid,
	input wire mac_beat_t o_mac_tx_beat,
	input wire logic o_rx_valid,
	input wire rx_word_t o_rx_word,
	input wire cnt_array_t o_lost_count,
	input wire cnt_array_t o_dup_count,
	input wire logic o_report_valid,
	input wire cnt_array_t o_report_lost,
	input wire cnt_array_t o_report_dup
);
	localparam int V_LAST = LEN_VIDEO / WORD_OCTETS - 1; // Last video word index
	localparam int P_LAST = LEN_PDH / WORD_OCTETS - 1; // Last 512-octet word index
	logic up_q; // Connection level one cycle back
	service_t svc_q; // Service captured at setup
	logic [7:0] nword; // Words delivered so far in this unit
	logic is_vid; // Captured service is a video kind
	assign is_vid = svc_q inside {SVC_VID_TV, SVC_VID_HIGH, SVC_VID_P64};
	// Capture the service and count delivered words
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			up_q <= 1'b0;
			svc_q <= SVC_PDH_SYNC;
			nword <= 8'h00;
		end else begin
			up_q <= i_conn_up;
			if (i_conn_up && !up_q) begin
				svc_q <= i_service;
			end
			if (o_rx_valid) begin
				nword <= o_rx_word.last ? 8'h00 : nword + 8'h01;
			end
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	////////////////////////////////////////////////////////////////////////
	property p_rx_data; o_rx_valid |-> $past(i_mac_rx_valid) && o_rx_word.data == $past(i_mac_rx_beat.data); endproperty
	a_rx_data: assert property (p_rx_data) else $error("word not from beat");
	property p_rx_len; o_rx_valid && o_rx_word.last |-> nword == (is_vid ? V_LAST : P_LAST); endproperty
	a_rx_len: assert property (p_rx_len) else $error("unit length wrong");
	property p_rx_gap; o_rx_valid && o_rx_word.last |=> !o_rx_valid [*2]; endproperty
	a_rx_gap: assert property (p_rx_gap) else $error("units too close");
	property p_tx_hold; o_mac_tx_valid && !i_mac_tx_ready |=> o_mac_tx_valid && $stable(o_mac_tx_beat); endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("beat dropped in stall");
	property p_tx_dummy; o_mac_tx_valid && o_mac_tx_beat.sof |-> !o_mac_tx_beat.data[HDR_DUMMY_BIT]; endproperty
	a_tx_dummy: assert property (p_tx_dummy) else $error("dummy sent");
	property p_rep_copy; o_report_valid |-> o_report_lost == $past(o_lost_count) && o_report_dup == $past(o_dup_count); endproperty
	a_rep_copy: assert property (p_rep_copy) else $error("report not counts");
	property p_rep_nonzero; o_report_valid |-> o_report_lost != '0 || o_report_dup != '0; endproperty
	a_rep_nonzero: assert property (p_rep_nonzero) else $error("empty report");
	property p_rep_clear; o_report_valid && !$past(i_mac_rx_valid) |-> o_lost_count == '0 && o_dup_count == '0; endproperty
	a_rep_clear: assert property (p_rep_clear) else $error("counts kept");
	property p_quiet; $changed(o_report_lost) && !o_report_valid |-> o_report_lost == '0; endproperty
	a_quiet: assert property (p_quiet) else $error("silent nonzero report");
	property p_lost_mono; !o_report_valid |-> o_lost_count[0] >= $past(o_lost_count[0]); endproperty
	a_lost_mono: assert property (p_lost_mono) else $error("lost count fell");
	c_report: cover property (o_report_valid);
	c_bound: cover property (o_rx_valid && o_rx_word.bound);
	c_error: cover property (o_rx_valid && o_rx_word.error);
	c_stall: cover property (o_mac_tx_valid && !i_mac_tx_ready);
endmodule

bind tdm_emulation_adapter tdm_adapt_checker #(.T_SEC_CYCLES(T_SEC_CYCLES)) u_chk (.i_clk,
	.i_rstn, .i_conn_up, .i_service, .i_mac_tx_ready, .i_mac_rx_valid, .i_mac_rx_beat,
	.o_mac_tx_valid, .o_mac_tx_beat, .o_rx_valid, .o_rx_word, .o_lost_count, .o_dup_count,
	.o_report_valid, .o_report_lost, .o_report_dup);
`default_nettype wire

// >>> ring_mac_model.sv
// Purpose: Behavioural ring pipe facing the adapter
// Assumes: Same clock as the adapter; sent units loop back to receive
// Notes: Can stall, shift sequence numbers and set the dummy flag
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ring_mac_model import tdm_adapt_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_slow, // Accept one beat in four
	input wire logic i_dummy, // Dummy flag for looped headers
	input wire logic [7:0] i_seq_adj, // Added to looped sequence numbers
	input wire logic i_tx_valid,
	input wire mac_beat_t i_tx_beat,
	output logic o_tx_ready,
	output logic o_rx_valid,
	output var mac_beat_t o_rx_beat
);
	logic [1:0] tick; // Stall pattern counter
	// Ready comes from the own counter, never from valid
	assign o_tx_ready = !i_slow || (tick == 2'h0);
	// Loop each accepted beat back one cycle later
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tick <= 2'h0;
			o_rx_valid <= 1'b0;
			o_rx_beat <= '0;
		end else begin
			tick <= tick + 2'h1;
			o_rx_valid <= i_tx_valid && o_tx_ready;
			if (i_tx_valid && o_tx_ready) begin
				o_rx_beat <= i_tx_beat;
				if (i_tx_beat.sof) begin
					o_rx_beat.data[SEQ_W-1:0] <= i_tx_beat.data[SEQ_W-1:0] + i_seq_adj;
					o_rx_beat.data[HDR_DUMMY_BIT] <= i_dummy;
				end
			end else begin
				o_rx_beat <= ~o_rx_beat; // Idle lines invert the held beat each cycle, so the stale beat shows again every second idle cycle
			end
		end
	end
endmodule
`default_nettype wire

// >>> tdm_adapt_tb.sv
// Purpose: Self-checking bench for the TDM emulation adapter
// Assumes: Ring side is the loopback model; a second is 10 cycles
// Notes: Counts checked live, then through periodic reports
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_top import tdm_adapt_pkg::*;;
	localparam int T_SEC = 10; // Cycles per simulated second
	logic i_clk, i_rstn, i_conn_up, i_struct_en, i_period_long, i_tx_valid;
	service_t i_service;
	logic [TRIB_W-1:0] i_tx_trib;
	logic [31:0] i_period_sec;
	tx_word_t i_tx_word;
	wire logic i_mac_tx_ready, i_mac_rx_valid, o_tx_ready, o_mac_tx_valid, o_rx_valid;
	wire logic o_report_valid;
	wire mac_beat_t i_mac_rx_beat, o_mac_tx_beat;
	wire rx_word_t o_rx_word;
	wire cnt_array_t o_lost_count, o_dup_count, o_report_lost, o_report_dup;
	wire logic [CNT_W-1:0] o_report_crc;
	logic slow, dummy; // Ring stall and dummy-fill controls
	logic [7:0] adj; // Sequence shift applied by the ring
	int err_total, total_checks, cyc, seed, nrep, nfull;
	rx_word_t expq[$]; // Words still to be delivered
	cnt_array_t ml, md, sl, sd; // Expected and summed reported counts
	logic [7:0] nexp [NTRIB]; // Next expected sequence per tributary
	logic seen [NTRIB];
	logic [7:0] adjtab [6] = '{8'h00, 8'h00, 8'h03, 8'hFE, 8'h7F, 8'h80};

	tdm_emulation_adapter #(.T_SEC_CYCLES(T_SEC)) dut (.i_clk, .i_rstn, .i_conn_up, .i_service,
		.i_struct_en, .i_tx_trib, .i_period_sec, .i_period_long, .i_tx_valid, .i_tx_word,
		.o_tx_ready, .o_mac_tx_valid, .o_mac_tx_beat, .i_mac_tx_ready, .i_mac_rx_valid,
		.i_mac_rx_beat, .o_rx_valid, .o_rx_word, .o_lost_count, .o_dup_count,
		.o_report_valid, .o_report_lost, .o_report_dup, .o_report_crc);
	ring_mac_model u_mac (.i_clk, .i_rstn, .i_slow(slow), .i_dummy(dummy), .i_seq_adj(adj),
		.i_tx_valid(o_mac_tx_valid), .i_tx_beat(o_mac_tx_beat), .o_tx_ready(i_mac_tx_ready),
		.o_rx_valid(i_mac_rx_valid), .o_rx_beat(i_mac_rx_beat));

	// 100 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task stop_test();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk_word(input rx_word_t g, input rx_word_t e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_cnt(input cnt_array_t g, input cnt_array_t e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_val(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Payload words per unit for a service
	function automatic int len_of(input service_t s);
		case (s)
			SVC_VID_TV, SVC_VID_HIGH, SVC_VID_P64: return LEN_VIDEO / WORD_OCTETS;
			SVC_VOICE, SVC_ISDN_64, SVC_ISDN_HIGH: return LEN_VOICE / WORD_OCTETS;
			default: return LEN_PDH / WORD_OCTETS;
		endcase
	endfunction
	// Expected lost and duplicate counts from one received header
	task seq_upd(input logic [31:0] h);
		logic [1:0] t;
		logic [7:0] g;
		t = h[HDR_TRIB_LSB +: TRIB_W];
		g = h[HDR_SEQ_LSB +: SEQ_W] - nexp[t];
		if (seen[t] !== 1'b1) begin
			seen[t] = 1'b1;
			nexp[t] = h[7:0] + 8'h01;
		end else if (g < 8'h80) begin
			ml[t] = (ml[t] > CNT_MAX - g) ? CNT_MAX : ml[t] + g;
			nexp[t] = nexp[t] + g + 8'h01;
		end else begin
			md[t] = (md[t] == CNT_MAX) ? CNT_MAX : md[t] + 16'h0001;
		end
	endtask
	task clr();
		ml = '0;
		md = '0;
		sl = '0;
		sd = '0;
		nrep = 0;
		foreach (seen[k]) seen[k] = 1'b0;
	endtask
	// New connection; marker use only changes here
	task setup(input service_t s, input logic st);
		i_conn_up <= 1'b0;
		@(posedge i_clk);
		i_service <= s;
		i_struct_en <= st;
		i_conn_up <= 1'b1;
		repeat (2) @(posedge i_clk);
	endtask
	// Send one unit and wait until all of it is delivered
	task send(input logic sl_in, input logic [7:0] a, input logic d);
		int n, w;
		logic b;
		tx_word_t x;
		rx_word_t e;
		n = len_of(i_service);
		slow <= sl_in;
		adj <= a;
		dummy <= d;
		i_tx_trib <= (i_period_sec < 32'h10) ? 2'h0 : 2'($random(seed)); // Short periods: one trib
		b = 1'($random(seed));
		for (int i = 0; i < n; i++) begin
			x.bound = b && (i == 0);
			x.data = $random(seed);
			e = '{i_struct_en & x.bound, d, i == n - 1, x.data};
			expq.push_back(e);
			i_tx_valid <= 1'b1;
			i_tx_word <= x;
			@(posedge i_clk);
			for (w = 0; o_tx_ready !== 1'b1 && w < 100; w++) @(posedge i_clk);
		end
		i_tx_valid <= 1'b0;
		for (w = 0; expq.size() > 0 && w < 2000; w++) @(posedge i_clk);
		chk_val(expq.size(), 0);
		repeat (3) @(posedge i_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watch ring headers, deliveries, reports and refusals
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			stop_test();
		end
		if (i_mac_rx_valid === 1'b1 && i_mac_rx_beat.sof === 1'b1)
			seq_upd(i_mac_rx_beat.data);
		if (o_rx_valid === 1'b1) begin
			if (expq.size() == 0)
				chk_val(1, 0);
			else
				chk_word(o_rx_word, expq.pop_front());
		end
		if (o_report_valid === 1'b1) begin
			nrep++;
			for (int k = 0; k < NTRIB; k++) begin
				sl[k] = sl[k] + o_report_lost[k];
				sd[k] = sd[k] + o_report_dup[k];
			end
		end
		if (i_tx_valid && o_tx_ready === 1'b0)
			nfull++;
	end
	// Main sequence
	initial begin
		int m;
		seed = 32'h9131;
		i_rstn = 1'b0;
		i_conn_up = 1'b0;
		i_service = SVC_PDH_SYNC;
		i_struct_en = 1'b0;
		i_tx_trib = 2'h0;
		i_period_sec = 32'h0010_0000;
		i_period_long = 1'b0;
		i_tx_valid = 1'b0;
		i_tx_word = '0;
		slow = 1'b0;
		dummy = 1'b0;
		adj = 8'h00;
		clr();
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk_cnt(o_lost_count, '0);
		for (int k = 0; k < 8; k++) begin
			setup(service_t'(k), k[0]);
			send(k[1], 8'h00, 1'b0);
		end
		chk_val(nfull > 0, 1);
		setup(SVC_VID_TV, 1'b1);
		for (int k = 0; k < 12; k++) begin
			send(1'($random(seed)), adjtab[{$random(seed)} % 6], 1'($random(seed)));
			chk_cnt(o_lost_count, ml);
			chk_cnt(o_dup_count, md);
		end
		i_rstn <= 1'b0;
		i_period_sec <= 32'h0000_0002;
		repeat (2) @(posedge i_clk);
		chk_cnt(o_dup_count, '0);
		clr();
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_clk);
		setup(SVC_VID_P64, 1'b0);
		for (int k = 0; k < 4; k++) send(1'b0, adjtab[k + 2], 1'b0);
		repeat (80) @(posedge i_clk);
		chk_cnt(sl, ml);
		chk_cnt(sd, md);
		chk_cnt(o_lost_count, '0);
		chk_val(nrep > 0, 1);
		chk_val(o_report_crc, 0);
		m = nrep;
		repeat (80) @(posedge i_clk);
		chk_val(nrep, m);
		stop_test();
	end
endmodule
`default_nettype wire
